// ==== design/gpi_eval.v ====
`timescale 1ns/1ns
`default_nettype none
`include "gpi_consts.vh"

module gpi_eval (
  input wire [`GPI_PIN_W-1:0] first_pins_i,
  input wire [`GPI_PIN_W-1:0] second_pins_i,
  input wire [`GPI_PIN_W-1:0] first_pol_i,
  input wire [`GPI_PIN_W-1:0] second_pol_i,
  input wire [`GPI_PIN_W-1:0] first_en_i,
  input wire [`GPI_PIN_W-1:0] second_en_i,
  input wire combine_all_i,
  output reg cond_o
);

  wire [2*`GPI_PIN_W-1:0] pins;
  wire [2*`GPI_PIN_W-1:0] pol;
  wire [2*`GPI_PIN_W-1:0] en;
  wire [2*`GPI_PIN_W-1:0] active;

  assign pins = {second_pins_i, first_pins_i};
  assign pol = {second_pol_i, first_pol_i};
  assign en = {second_en_i, first_en_i};
  // Polarity one means active high, zero active low
  assign active = ~(pins ^ pol) & en;

  // An empty enable set never fires, even when combining for all
  always @*
  begin
    if (combine_all_i == `GPI_COMBINE_ALL)
      cond_o = (active == en) && (|en);
    else
      cond_o = |active;
  end

endmodule // gpi_eval

`default_nettype wire

// ==== design/gpi_sync.v ====
`timescale 1ns/1ns
`default_nettype none
`include "gpi_consts.vh"

module gpi_sync (
  input wire mclk_i,
  input wire reset_i,
  input wire [`GPI_PIN_W-1:0] pins_i,
  output wire [`GPI_PIN_W-1:0] pins_o
);

  reg [`GPI_PIN_W-1:0] meta_q;
  reg [`GPI_PIN_W-1:0] sync_q;

  genvar gi;
  generate
    for (gi = 0; gi < `GPI_PIN_W; gi = gi + 1)
    begin : g_bit
      // First stage is seen only by the second one
      always @(posedge mclk_i or posedge reset_i)
      begin
        if (reset_i)
        begin
          meta_q[gi] <= 1'b0;
          sync_q[gi] <= 1'b0;
        end
        else
        begin
          meta_q[gi] <= pins_i[gi];
          sync_q[gi] <= meta_q[gi];
        end
      end
    end
  endgenerate

  assign pins_o = sync_q;

endmodule // gpi_sync

`default_nettype wire

// ==== design/gpi_top.v ====
// Operation
// - Combine-any: request when at least one enabled pin is active.
// - Combine-all: request only while every enabled pin is active.
// - Edge mode: request on rising transition of combined condition.
// - Level mode: request held while combined condition stays true.
// - Polarity bit 0 means active low, 1 means active high.
// - Enable bit 0 excludes a pin, 1 includes it.
// - Pins are monitored once enabled, regardless of interrupt delivery.
// - Masking the interrupt only blocks delivery, monitoring continues.
// - Status bit reads 1 while a group request is recorded.
// - Software clears the status bit; in level mode a still-true condition keeps it set.
// - Modes, polarity and enable masks read back as last written.
`timescale 1ns/1ns
`default_nettype none
`include "gpi_consts.vh"

module gpi_top (
  input wire mclk_i,
  input wire reset_i,
  input wire [`GPI_PIN_W-1:0] first_port_pins_i,
  input wire [`GPI_PIN_W-1:0] second_port_pins_i,
  output reg irq_o,
  input wire [`GPI_ADDR_W-1:0] s_axi_awaddr_i,
  input wire s_axi_awvalid_i,
  output reg s_axi_awready_o,
  input wire [`GPI_DATA_W-1:0] s_axi_wdata_i,
  input wire [`GPI_STRB_W-1:0] s_axi_wstrb_i,
  input wire s_axi_wvalid_i,
  output reg s_axi_wready_o,
  output reg [1:0] s_axi_bresp_o,
  output reg s_axi_bvalid_o,
  input wire s_axi_bready_i,
  input wire [`GPI_ADDR_W-1:0] s_axi_araddr_i,
  input wire s_axi_arvalid_i,
  output reg s_axi_arready_o,
  output reg [`GPI_DATA_W-1:0] s_axi_rdata_o,
  output reg [1:0] s_axi_rresp_o,
  output reg s_axi_rvalid_o,
  input wire s_axi_rready_i
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  reg [1:0] ctrl_q;
  reg mask_q;
  reg status_q;
  reg status_d;
  reg cond_prev_q;
  reg [`GPI_PIN_W-1:0] first_pol_q;
  reg [`GPI_PIN_W-1:0] first_en_q;
  reg [`GPI_PIN_W-1:0] second_pol_q;
  reg [`GPI_PIN_W-1:0] second_en_q;

  reg aw_held_q;
  reg aw_held_d;
  reg [`GPI_ADDR_W-1:0] awaddr_q;
  reg w_held_q;
  reg w_held_d;
  reg [`GPI_DATA_W-1:0] wdata_q;
  reg [`GPI_STRB_W-1:0] wstrb_q;
  reg bvalid_d;
  reg rvalid_d;
  reg [`GPI_DATA_W-1:0] rdata_d;
  reg [1:0] rresp_d;
  reg [1:0] bresp_d;

  wire [`GPI_PIN_W-1:0] first_sync;
  wire [`GPI_PIN_W-1:0] second_sync;
  wire cond;
  wire group_set;
  wire aw_hs;
  wire w_hs;
  wire ar_hs;
  wire do_wr;
  wire [`GPI_ADDR_W-1:0] wr_addr;
  wire [`GPI_ADDR_W-1:0] rd_addr;
  wire status_clr;

  ////////////////////////////////////////////////////////////////////////////
  // Byte-lane merge for wide registers

  function [`GPI_DATA_W-1:0] merge_lanes;
    input [`GPI_DATA_W-1:0] old_v;
    input [`GPI_DATA_W-1:0] new_v;
    input [`GPI_STRB_W-1:0] strb;
    integer b;
    begin
      merge_lanes = old_v;
      for (b = 0; b < `GPI_STRB_W; b = b + 1)
      begin
        if (strb[b])
          merge_lanes[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and group evaluation

  gpi_sync u_sync_first (
    .mclk_i (mclk_i),
    .reset_i (reset_i),
    .pins_i (first_port_pins_i),
    .pins_o (first_sync)
  );

  gpi_sync u_sync_second (
    .mclk_i (mclk_i),
    .reset_i (reset_i),
    .pins_i (second_port_pins_i),
    .pins_o (second_sync)
  );

  // Evaluation runs whatever the interrupt mask holds
  gpi_eval u_eval (
    .first_pins_i (first_sync),
    .second_pins_i (second_sync),
    .first_pol_i (first_pol_q),
    .second_pol_i (second_pol_q),
    .first_en_i (first_en_q),
    .second_en_i (second_en_q),
    .combine_all_i (ctrl_q[`GPI_CTRL_COMBINE_BIT]),
    .cond_o (cond)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Group status

  // A config write can make a fresh edge; that is treated as a real one
  assign group_set = (ctrl_q[`GPI_CTRL_SENSE_BIT] == `GPI_SENSE_LEVEL) ?
                     cond :
                     (cond & ~cond_prev_q);

  assign status_clr = do_wr && (wr_addr == `GPI_OFF_STATUS) && wstrb_q[0] &&
                      wdata_q[`GPI_STAT_GROUP_BIT];

  // Set wins over clear, so a level source re-asserts right away
  always @*
  begin
    status_d = group_set | (status_q & ~status_clr);
  end

  always @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      status_q <= 1'b0;
      cond_prev_q <= 1'b0;
      irq_o <= 1'b0;
    end
    else
    begin
      status_q <= status_d;
      cond_prev_q <= cond;
      irq_o <= status_d & mask_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write channels

  assign aw_hs = s_axi_awvalid_i & s_axi_awready_o;
  assign w_hs = s_axi_wvalid_i & s_axi_wready_o;
  assign do_wr = aw_held_q & w_held_q & ~s_axi_bvalid_o;
  assign wr_addr = {awaddr_q[`GPI_ADDR_W-1:2], 2'h0};

  always @*
  begin
    aw_held_d = do_wr ? 1'b0 : (aw_held_q | aw_hs);
    w_held_d = do_wr ? 1'b0 : (w_held_q | w_hs);
    bvalid_d = do_wr ? 1'b1 : (s_axi_bvalid_o & ~s_axi_bready_i);
    if (wr_addr == `GPI_OFF_CTRL || wr_addr == `GPI_OFF_STATUS ||
        wr_addr == `GPI_OFF_MASK || wr_addr == `GPI_OFF_FIRST_POL ||
        wr_addr == `GPI_OFF_FIRST_EN || wr_addr == `GPI_OFF_SECOND_POL ||
        wr_addr == `GPI_OFF_SECOND_EN)
      bresp_d = `GPI_RESP_OKAY;
    else
      bresp_d = `GPI_RESP_SLVERR;
  end

  always @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= {`GPI_ADDR_W{1'b0}};
      wdata_q <= `GPI_RST_DATA;
      wstrb_q <= {`GPI_STRB_W{1'b0}};
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o <= 1'b0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= `GPI_RESP_OKAY;
    end
    else
    begin
      aw_held_q <= aw_held_d;
      w_held_q <= w_held_d;
      if (aw_hs)
        awaddr_q <= s_axi_awaddr_i;
      if (w_hs)
      begin
        wdata_q <= s_axi_wdata_i;
        wstrb_q <= s_axi_wstrb_i;
      end
      // One write in flight; channels reopen after the response is taken
      s_axi_awready_o <= ~aw_held_d & ~bvalid_d;
      s_axi_wready_o <= ~w_held_d & ~bvalid_d;
      s_axi_bvalid_o <= bvalid_d;
      if (do_wr)
        s_axi_bresp_o <= bresp_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers

  always @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      ctrl_q <= `GPI_RST_CTRL;
      mask_q <= `GPI_RST_MASK;
      first_pol_q <= `GPI_RST_POL;
      first_en_q <= `GPI_RST_EN;
      second_pol_q <= `GPI_RST_POL;
      second_en_q <= `GPI_RST_EN;
    end
    else if (do_wr)
    begin
      if (wr_addr == `GPI_OFF_CTRL)
      begin
        if (wstrb_q[0])
          ctrl_q <= wdata_q[1:0];
      end
      else if (wr_addr == `GPI_OFF_MASK)
      begin
        if (wstrb_q[0])
          mask_q <= wdata_q[`GPI_STAT_GROUP_BIT];
      end
      else if (wr_addr == `GPI_OFF_FIRST_POL)
        first_pol_q <= merge_lanes(first_pol_q, wdata_q, wstrb_q);
      else if (wr_addr == `GPI_OFF_FIRST_EN)
        first_en_q <= merge_lanes(first_en_q, wdata_q, wstrb_q);
      else if (wr_addr == `GPI_OFF_SECOND_POL)
        second_pol_q <= merge_lanes(second_pol_q, wdata_q, wstrb_q);
      else if (wr_addr == `GPI_OFF_SECOND_EN)
        second_en_q <= merge_lanes(second_en_q, wdata_q, wstrb_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel

  assign ar_hs = s_axi_arvalid_i & s_axi_arready_o;
  assign rd_addr = {s_axi_araddr_i[`GPI_ADDR_W-1:2], 2'h0};

  always @*
  begin
    rdata_d = `GPI_RST_DATA;
    rresp_d = `GPI_RESP_OKAY;
    if (rd_addr == `GPI_OFF_CTRL)
      rdata_d[1:0] = ctrl_q;
    else if (rd_addr == `GPI_OFF_STATUS)
    begin
      rdata_d[`GPI_STAT_GROUP_BIT] = status_q;
      rdata_d[`GPI_STAT_LIVE_BIT] = cond;
    end
    else if (rd_addr == `GPI_OFF_MASK)
      rdata_d[`GPI_STAT_GROUP_BIT] = mask_q;
    else if (rd_addr == `GPI_OFF_FIRST_POL)
      rdata_d = first_pol_q;
    else if (rd_addr == `GPI_OFF_FIRST_EN)
      rdata_d = first_en_q;
    else if (rd_addr == `GPI_OFF_SECOND_POL)
      rdata_d = second_pol_q;
    else if (rd_addr == `GPI_OFF_SECOND_EN)
      rdata_d = second_en_q;
    else
      rresp_d = `GPI_RESP_SLVERR;
    rvalid_d = ar_hs ? 1'b1 : (s_axi_rvalid_o & ~s_axi_rready_i);
  end

  always @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= `GPI_RST_DATA;
      s_axi_rresp_o <= `GPI_RESP_OKAY;
    end
    else
    begin
      s_axi_arready_o <= ~rvalid_d;
      s_axi_rvalid_o <= rvalid_d;
      if (ar_hs)
      begin
        s_axi_rdata_o <= rdata_d;
        s_axi_rresp_o <= rresp_d;
      end
    end
  end

endmodule // gpi_top

`default_nettype wire

// ==== shared/gpi_consts.vh ====
`ifndef GPI_CONSTS_VH
`define GPI_CONSTS_VH

// Pins per port and bus widths
`define GPI_PIN_W 32
`define GPI_ADDR_W 8
`define GPI_DATA_W 32
`define GPI_STRB_W 4

// Register byte offsets
`define GPI_OFF_CTRL 8'h00
`define GPI_OFF_STATUS 8'h04
`define GPI_OFF_MASK 8'h08
`define GPI_OFF_FIRST_POL 8'h0c
`define GPI_OFF_FIRST_EN 8'h10
`define GPI_OFF_SECOND_POL 8'h14
`define GPI_OFF_SECOND_EN 8'h18

// Field positions
`define GPI_CTRL_COMBINE_BIT 0
`define GPI_CTRL_SENSE_BIT 1
`define GPI_STAT_GROUP_BIT 0
`define GPI_STAT_LIVE_BIT 1

// Field encodings
`define GPI_COMBINE_ANY 1'b0
`define GPI_COMBINE_ALL 1'b1
`define GPI_SENSE_EDGE 1'b0
`define GPI_SENSE_LEVEL 1'b1

// Reset values
`define GPI_RST_CTRL 2'h0
`define GPI_RST_MASK 1'h0
`define GPI_RST_POL 32'h00000000
`define GPI_RST_EN 32'h00000000
`define GPI_RST_DATA 32'h00000000

// Bus responses
`define GPI_RESP_OKAY 2'h0
`define GPI_RESP_SLVERR 2'h2

`endif

// ==== verif/gpi_pins.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "gpi_consts.vh"
module gpi_pins (
  input wire logic mclk_i,
  input wire logic [`GPI_PIN_W-1:0] first_set_i,
  input wire logic [`GPI_PIN_W-1:0] second_set_i,
  output logic [`GPI_PIN_W-1:0] first_port_pins_o,
  output logic [`GPI_PIN_W-1:0] second_port_pins_o
);
  // Switches move mid-cycle, so the result hangs on the input synchronisers
  always @(negedge mclk_i)
  begin
    first_port_pins_o <= first_set_i;
    second_port_pins_o <= second_set_i;
  end
endmodule // gpi_pins
`default_nettype wire

// ==== verif/gpi_top_sva.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "gpi_consts.vh"
module gpi_top_sva (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic [`GPI_PIN_W-1:0] first_port_pins_i,
  input wire logic [`GPI_PIN_W-1:0] second_port_pins_i,
  input wire logic irq_o,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [`GPI_ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [`GPI_DATA_W-1:0] s_axi_rdata_o,
  input wire logic [1:0] s_axi_rresp_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i
);
  logic [3:0] quiet_q;
  wire logic ar_hs = s_axi_arvalid_i && s_axi_arready_o;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  // Cycles since a pin moved or a write landed; irq has no other cause
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
      quiet_q <= 4'h0;
    else if ($changed(first_port_pins_i) || $changed(second_port_pins_i) ||
             (s_axi_wvalid_i && s_axi_wready_o) || s_axi_bvalid_o)
      quiet_q <= 4'h0;
    else if (quiet_q != 4'hf)
      quiet_q <= quiet_q + 4'h1;
  end
  chk_irq_cause: assert property (quiet_q >= 4'h5 |-> $stable(irq_o))
    else $error("irq moved without a cause");
  chk_b_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
    else $error("bvalid dropped early");
  chk_b_done: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
    else $error("bvalid held after taken");
  chk_w_answer: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i &&
    s_axi_wready_o |-> ##[1:2] s_axi_bvalid_o)
    else $error("no write answer");
  chk_aw_block: assert property (s_axi_awvalid_i && s_axi_awready_o |=> !s_axi_awready_o)
    else $error("awready not refused");
  chk_r_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
    s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read answer unstable");
  chk_ar_block: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("arready while rvalid");
  chk_r_answer: assert property (ar_hs |=> s_axi_rvalid_o)
    else $error("no read answer");
  chk_rd_unmapped: assert property (ar_hs && s_axi_araddr_i >= 8'h1c |=>
    s_axi_rresp_o == `GPI_RESP_SLVERR && s_axi_rdata_o == 32'h0)
    else $error("unmapped read not refused");
  chk_rd_mapped: assert property (ar_hs && s_axi_araddr_i < 8'h1c |=>
    s_axi_rresp_o == `GPI_RESP_OKAY)
    else $error("mapped read refused");
  cov_irq: cover property ($rose(irq_o));
  cov_irq_off: cover property ($fell(irq_o));
  cov_slverr: cover property (s_axi_rvalid_o && s_axi_rresp_o == `GPI_RESP_SLVERR);
endmodule // gpi_top_sva
bind gpi_top gpi_top_sva i_chk (.mclk_i, .reset_i, .first_port_pins_i, .second_port_pins_i,
  .irq_o, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o,
  .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o,
  .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i);
`default_nettype wire

// ==== verif/testbench.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "gpi_consts.vh"
module testbench;
  logic clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic [31:0] fset = 32'h0, sset = 32'h0, wd = 32'h0, rd;
  logic [7:0] awa = 8'h0, ara = 8'h0;
  logic [3:0] ws = 4'hf;
  logic [1:0] rs;
  wire logic [31:0] fpin, spin, rdata;
  wire logic awr, wrd, bv, arr, rv, irq;
  wire logic [1:0] bresp, rresp;
  int miscompares = 0;
  int tests_run = 0;
  gpi_pins i_pins (.mclk_i(clk), .first_set_i(fset), .second_set_i(sset),
    .first_port_pins_o(fpin), .second_port_pins_o(spin));
  gpi_top i_dut (.mclk_i(clk), .reset_i(rst), .first_port_pins_i(fpin),
    .second_port_pins_i(spin), .irq_o(irq), .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv),
    .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(ws), .s_axi_wvalid_i(wv),
    .s_axi_wready_o(wrd), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv), .s_axi_bready_i(br),
    .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv), .s_axi_rready_i(rr));
  initial
    forever #5 clk = ~clk;
  //////////////////////////////////////////////////////////////////////////////////////////
  task final_report;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One bus cycle, write when w is set; a hang is ended by the bench timeout
  task axi(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    awa <= a;
    ara <= a;
    wd <= d;
    awv <= w;
    wv <= w;
    br <= w;
    arv <= !w;
    rr <= !w;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
      if (arr) arv <= 1'b0;
    end
    while ((w ? bv : rv) !== 1'b1);
    check(n, w ? 32'h3 : 32'h2);
    rs = w ? bresp : rresp;
    rd = rdata;
    br <= 1'b0;
    rr <= 1'b0;
  endtask
  task set_pins(input logic [31:0] f, input logic [31:0] s);
    @(posedge clk);
    fset <= f;
    sset <= s;
    repeat (6) @(posedge clk);
  endtask
  task chk_stat(input logic [31:0] s, input logic q);
    axi(1'b0, 8'h04, 32'h0);
    check(rd, s);
    check({31'h0, irq}, {31'h0, q});
  endtask
  //////////////////////////////////////////////////////////////////////////////////////////
  task t_reset;
    logic [3:0] i;
    for (i = 4'h0; i < 4'h7; i++)
    begin
      axi(1'b0, {2'b00, i, 2'b00}, 32'h0);
      check(rd, 32'h0);
    end
    check({31'h0, irq}, 32'h0);
    $display("reset values done");
  endtask
  task t_readback;
    logic [3:0] i;
    logic [31:0] v;
    for (i = 4'h0; i < 4'h7; i++)
      if (i != 4'h1)
      begin
        axi(1'b1, {2'b00, i, 2'b00}, 32'h96c35a0f ^ {8{i}});
        check({30'h0, rs}, {30'h0, `GPI_RESP_OKAY});
      end
    axi(1'b1, 8'h1c, 32'hffffffff);
    check({30'h0, rs}, {30'h0, `GPI_RESP_SLVERR});
    for (i = 4'h0; i < 4'h7; i++)
      if (i != 4'h1)
      begin
        v = 32'h96c35a0f ^ {8{i}};
        axi(1'b0, {2'b00, i, 2'b00}, 32'h0);
        check(rd, i == 4'h0 ? v & 32'h3 : i == 4'h2 ? v & 32'h1 : v);
      end
    ws <= 4'h2;
    axi(1'b1, 8'h0c, 32'hffffffff);
    ws <= 4'hf;
    axi(1'b0, 8'h0c, 32'h0);
    check(rd, 32'ha5f0ff3c);
    axi(1'b0, 8'hfc, 32'h0);
    check({rd[29:0], rs}, {30'h0, `GPI_RESP_SLVERR});
    for (i = 4'h0; i < 4'h7; i++)
      axi(1'b1, {2'b00, i, 2'b00}, {31'h0, i == 4'h1});
    chk_stat(32'h0, 1'b0);
    $display("readback done");
  endtask
  task t_any_level;
    set_pins(32'h0, 32'h8);
    axi(1'b1, 8'h0c, 32'h1);
    axi(1'b1, 8'h10, 32'h1);
    axi(1'b1, 8'h18, 32'h8);
    axi(1'b1, 8'h08, 32'h1);
    axi(1'b1, 8'h00, 32'h2);
    chk_stat(32'h0, 1'b0);
    set_pins(32'h2, 32'h8);
    chk_stat(32'h0, 1'b0);
    set_pins(32'h2, 32'h0);
    chk_stat(32'h3, 1'b1);
    set_pins(32'h2, 32'h8);
    chk_stat(32'h1, 1'b1);
    axi(1'b1, 8'h04, 32'h1);
    chk_stat(32'h0, 1'b0);
    set_pins(32'h1, 32'h8);
    axi(1'b1, 8'h04, 32'h1);
    chk_stat(32'h3, 1'b1);
    set_pins(32'h0, 32'h8);
    axi(1'b1, 8'h04, 32'h1);
    chk_stat(32'h0, 1'b0);
    $display("any level done");
  endtask
  task t_all_edge;
    axi(1'b1, 8'h08, 32'h0);
    axi(1'b1, 8'h00, 32'h1);
    set_pins(32'h1, 32'h8);
    chk_stat(32'h0, 1'b0);
    set_pins(32'h1, 32'h0);
    chk_stat(32'h3, 1'b0);
    axi(1'b1, 8'h08, 32'h1);
    chk_stat(32'h3, 1'b1);
    set_pins(32'h0, 32'h0);
    chk_stat(32'h1, 1'b1);
    axi(1'b1, 8'h04, 32'h1);
    chk_stat(32'h0, 1'b0);
    set_pins(32'h1, 32'h0);
    chk_stat(32'h3, 1'b1);
    $display("all edge done");
  endtask
  //////////////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (3000) @(posedge clk);
    miscompares++;
    final_report;
  end
  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_readback;
    t_any_level;
    t_all_edge;
    final_report;
  end
endmodule // testbench
`default_nettype wire
